// ---- rtl/adcsr_top.sv ----
/*
 * Serial conversion-and-readout logic of a 10-bit converter: select
 * pin, host shift clock, three-state data pin, abstracted core.
 * Assumes a host master with clock polarity and phase zero; the shift
 * clock is its own domain and may stop outside frames.
 */
// Function
// RULE_01 - Select pin high keeps core powered down and idle.
// RULE_02 - Host waits the wake-up time before its first shift clock.
// RULE_03 - Internal mode frame: done flag, two ones, channel, data, sub-bits.
// RULE_04 - External mode frame: three ones, channel, data MSB first, sub-bits.
// RULE_05 - Host lowers select with shift clock low for external mode.
// RULE_06 - Host gives at least sixteen shift clocks per conversion.
// RULE_07 - Data changes on falling edges; host captures on rising edges.
// RULE_08 - Host ends a full read no earlier than the sixteenth fall.
// RULE_09 - Clocks beyond the last sub-bit shift out zeros.
// RULE_10 - Host holds select high at least 60 ns between frames.
// RULE_11 - Early select rise aborts conversion; new start after 60 ns.
// RULE_12 - External mode shift clock between 100 kHz and 2.17 MHz; the bench host clocks at 160 ns, 6.25 MHz.
// RULE_13 - Host master uses clock polarity zero and phase zero.
// RULE_14 - Two bytes: ones, channel, D9-D6; then D5-D0, sub-bits.
// RULE_15 - Each falling edge of select wakes and starts a conversion.
// RULE_16 - Shift clock high at select fall means internal mode.
// RULE_17 - External mode samples on the second falling shift edge.
// RULE_18 - Channel bit is 0 for channel zero, 1 otherwise.
// RULE_19 - Two-channel part starts on channel zero, then alternates.
// RULE_20 - Data pin floats while select is high.
// RULE_21 - Internal mode drives data low until conversion done, then high.
`timescale 1ns/100ps
`default_nettype none
`include "adcsr_regs.svh"

module adcsr_top
   import adcsr_pkg::*;
#(
   parameter logic [15:0] INT_CONV_CYCLES = `ADCSR_CONV_CYC_DEF,
   parameter bit DUAL_CHANNEL = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic sclk_i,
   input wire logic select_shutdown_n_i,
   input wire adcsr_code_t ch0_code_i,
   input wire adcsr_code_t ch1_code_i,
   output adcsr_dout_t serial_out_o,
   output logic core_power_o,
   output logic core_sample_o,
   output logic core_chan_o
);

   localparam int TCS_CYC = `ADCSR_TCS_CYC;

   // ****************************************************************
   // Link domain, clocked by falling shift-clock edges; rise_q by rising ones
   // ****************************************************************
   adcsr_link_t lk_q;
   adcsr_link_t lk_d;
   adcsr_core_t c_q;
   adcsr_core_t c_d;
   logic link_rst;
   logic rise_q;
   logic sclk_n;
   logic ack_s;
   logic [4:0] nx;
   logic [11:0] src;
   logic cs_s;
   logic sel_s;
   logic req_s;
   logic cs_fall;

   // Frame ends with the select pin itself, no shift edge is needed
   // RULE_01 frame cleared
   assign link_rst = rst_i | select_shutdown_n_i;
   assign sclk_n = ~sclk_i;

   // Any rising edge before the first fall means the clock idled low
   // RULE_16 mode detect
   always_ff @(posedge sclk_i or posedge link_rst) begin
      if (link_rst) begin
         rise_q <= 1'b0;
      end else begin
         rise_q <= 1'b1;
      end
   end

   // Result handshake acknowledge brought into the link domain
   adcsr_sync #(.W(1)) u_ack_sync (
      .clk_i(sclk_n),
      .rst_i(link_rst),
      .ce_i(1'b1),
      .d_i(c_q.ack),
      .q_o(ack_s)
   );

   // Frame sequencer and output shifter
   always_comb begin
      lk_d = lk_q;
      src = '0;
      nx = (lk_q.cnt == `ADCSR_CYC_TRAIL) ? lk_q.cnt : lk_q.cnt + 5'h01;
      lk_d.cnt = nx;
      if (lk_q.cnt == `ADCSR_CYC_IDLE) begin
         lk_d.mode_int = ~rise_q;
      end
      // RULE_17 sample request
      if ((lk_q.cnt == `ADCSR_CYC_IDLE && ~rise_q) ||
          (lk_q.cnt == `ADCSR_CYC_SMP_EXT && ~lk_q.mode_int)) begin
         lk_d.req = 1'b1;
      end
      // RULE_03 frame layout
      // RULE_04 frame layout
      // RULE_14 byte split
      if (nx <= `ADCSR_CYC_ONES_END) begin
         lk_d.out_bit = 1'b1;
      end else if (nx == `ADCSR_CYC_CHANNEL_ID_BIT) begin
         // RULE_18 channel bit
         lk_d.out_bit = c_q.chan_cur;
      end else if (nx == `ADCSR_CYC_MSB) begin
         // Zeros rather than a word caught mid-change
         src = ack_s ? c_q.result : '0;
         lk_d.out_bit = src[11];
         lk_d.data = {src[10:0], 1'b0};
      end else if (nx <= `ADCSR_CYC_LAST) begin
         lk_d.out_bit = lk_q.data[11];
         lk_d.data = {lk_q.data[10:0], 1'b0};
      end else begin
         // RULE_09 trailing zeros
         lk_d.out_bit = 1'b0;
      end
   end

   // Data only moves on falling shift edges
   // RULE_07 falling edge
   always_ff @(negedge sclk_i or posedge link_rst) begin
      if (link_rst) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   // Before the first fall the pin is low; in internal mode the
   // done flag shows until the second fall
   // RULE_21 done flag
   // RULE_20 float deselected
   assign serial_out_o.data = (lk_q.mode_int &&
                               lk_q.cnt == `ADCSR_CYC_FIRST) ?
                              c_q.eoc : lk_q.out_bit;
   assign serial_out_o.oe = ~select_shutdown_n_i & ~rst_i;

   // ****************************************************************
   // Core domain, system clock
   // ****************************************************************
   // Select carried as active high: the synchroniser resets to zero,
   // which must read as deselected or reset fakes a select fall
   adcsr_sync #(.W(2)) u_pin_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i({~select_shutdown_n_i, lk_q.req}),
      .q_o({sel_s, req_s})
   );

   assign cs_s = ~sel_s;

   assign cs_fall = c_q.cs_prev & ~cs_s;

   // Channel pointer, sampling and the internal conversion timer.
   // The channel bit is read by the link while quasi-static: it
   // settles long before the first shift edge thanks to the wake time.
   // RULE_02 wake margin
   always_comb begin
      c_d = c_q;
      c_d.cs_prev = cs_s;
      c_d.power = ~cs_s;
      c_d.sample = 1'b0;
      // RULE_15 start on fall
      // RULE_19 alternate channel
      if (cs_fall) begin
         c_d.chan_cur = DUAL_CHANNEL ? c_q.chan_next : `ADCSR_CHANNEL_ID_BIT_SINGLE;
         c_d.chan_next = ~c_q.chan_next;
      end
      case (c_q.state)
         ADCSR_IDLE: begin
            if (req_s && !cs_s) begin
               c_d.sample = 1'b1;
               c_d.result = c_q.chan_cur ? ch1_code_i : ch0_code_i;
               // Link holds its mode flag steady while requesting
               c_d.mode_int = lk_q.mode_int;
               if (lk_q.mode_int) begin
                  c_d.state = ADCSR_CONV;
                  c_d.timer = INT_CONV_CYCLES - 16'h0001;
               end else begin
                  c_d.state = ADCSR_HOLD;
                  c_d.ack = 1'b1;
               end
            end
         end
         ADCSR_CONV: begin
            if (c_q.timer == 16'h0000) begin
               c_d.state = ADCSR_HOLD;
               c_d.ack = 1'b1;
               c_d.eoc = 1'b1;
            end else begin
               c_d.timer = c_q.timer - 16'h0001;
            end
         end
         ADCSR_HOLD: begin
            c_d.state = ADCSR_HOLD;
         end
         default: begin
            c_d.state = ADCSR_IDLE;
         end
      endcase
      // Deselect ends or aborts the conversion and powers down
      // RULE_11 abort
      // RULE_01 shutdown
      if (!req_s || cs_s) begin
         c_d.state = ADCSR_IDLE;
         c_d.ack = 1'b0;
         c_d.eoc = 1'b0;
      end
   end

   // Core state register; clock enable freezes it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         c_q <= '0;
         c_q.cs_prev <= 1'b1;
      end else if (ce_i) begin
         c_q <= c_d;
      end
   end

   assign core_power_o = c_q.power;
   assign core_sample_o = c_q.sample;
   assign core_chan_o = c_q.chan_cur;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   shutdown_idle_a: // RULE_01
      assert property (@(posedge clk_i) disable iff (rst_i)
         (ce_i && cs_s) |=> (!core_power_o && c_q.state == ADCSR_IDLE))
      else $error("core not shut down while deselected");

   ones_lead_a: // RULE_04
      assert property (@(negedge sclk_i) disable iff (link_rst)
         (lk_q.cnt >= 5'h01 && lk_q.cnt <= 5'h03) |-> lk_q.out_bit)
      else $error("leading ones missing");

   chan_bit_a: // RULE_18
      assert property (@(negedge sclk_i) disable iff (link_rst)
         (lk_q.cnt == 5'h04) |-> (lk_q.out_bit == c_q.chan_cur))
      else $error("channel bit wrong");

   msb_first_a: // RULE_03
      assert property (@(negedge sclk_i) disable iff (link_rst)
         (lk_q.cnt == 5'h04 && ack_s) ##1 (lk_q.cnt == 5'h05)
         |-> (lk_q.out_bit == c_q.result.data[9]) ##10
             (lk_q.out_bit == c_q.result.sub[1]) ##1
             (lk_q.out_bit == c_q.result.sub[0]))
      else $error("data bits out of order");

   trail_zero_a: // RULE_09
      assert property (@(negedge sclk_i) disable iff (link_rst)
         (lk_q.cnt == 5'h11) |-> !serial_out_o.data)
      else $error("trailing bit not zero");

   ext_sample_a: // RULE_17
      assert property (@(negedge sclk_i) disable iff (link_rst)
         (!lk_q.mode_int && lk_q.cnt == 5'h01) |-> !lk_q.req ##1 lk_q.req)
      else $error("external sample not on second fall");

   conv_done_a: // RULE_21
      assert property (@(posedge clk_i) disable iff (rst_i)
         (ce_i && c_q.state == ADCSR_CONV && c_q.timer == 16'h0000 &&
          req_s && !cs_s) |=> (c_q.eoc && c_q.ack))
      else $error("done flag late");

   conv_low_a: // RULE_21
      assert property (@(posedge clk_i) disable iff (rst_i)
         (c_q.state == ADCSR_CONV) |-> !c_q.eoc)
      else $error("done flag high during conversion");

   abort_idle_a: // RULE_11
      assert property (@(posedge clk_i) disable iff (rst_i)
         ($rose(cs_s) && ce_i) |-> ##[1:TCS_CYC] (c_q.state == ADCSR_IDLE))
      else $error("abort not honoured");

   chan_toggle_a: // RULE_19
      assert property (@(posedge clk_i) disable iff (rst_i)
         (ce_i && cs_fall) |=> (c_q.chan_next != $past(c_q.chan_next)))
      else $error("channel did not alternate");

   pin_float_a: // RULE_20
      assert property (@(posedge clk_i) disable iff (rst_i)
         select_shutdown_n_i |-> !serial_out_o.oe)
      else $error("data pin driven while deselected");

   ext_frame_c:
      cover property (@(negedge sclk_i) disable iff (link_rst)
         !lk_q.mode_int && lk_q.cnt == 5'h10);

   int_done_c:
      cover property (@(posedge clk_i) disable iff (rst_i) $rose(c_q.eoc));

   abort_c:
      cover property (@(posedge clk_i) disable iff (rst_i)
         c_q.state == ADCSR_CONV && cs_s);

   trail_c:
      cover property (@(negedge sclk_i) disable iff (link_rst)
         lk_q.cnt == 5'h11);

endmodule // adcsr_top

`default_nettype wire

// ---- rtl/adcsr_regs.svh ----
/*
 * Constants of the converter serial readout: frame cycle positions,
 * timing figures and their cycle counts, default conversion length.
 * Assumes the system clock of 20 MHz; included by the package users.
 */
`ifndef ADCSR_REGS_SVH
`define ADCSR_REGS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define ADCSR_CLK_MHZ 20
// Least high time of the select pin between frames, in ns
`define ADCSR_TCS_NS 60
// Rounded up: a least time
`define ADCSR_TCS_CYC ((`ADCSR_TCS_NS * `ADCSR_CLK_MHZ + 999) / 1000)
// Internal-oscillator conversion length, in system clocks
`define ADCSR_CONV_CYC_DEF 16'h0064

// ****************************************************************
// Frame cycle positions, counted in falling shift-clock edges; channel bit of the single-channel part
// ****************************************************************
`define ADCSR_CYC_IDLE 5'h00
`define ADCSR_CYC_FIRST 5'h01
`define ADCSR_CYC_SMP_EXT 5'h01
`define ADCSR_CYC_ONES_END 5'h03
`define ADCSR_CYC_CHANNEL_ID_BIT 5'h04
`define ADCSR_CYC_MSB 5'h05
`define ADCSR_CYC_LAST 5'h10
`define ADCSR_CYC_TRAIL 5'h11
`define ADCSR_CHANNEL_ID_BIT_SINGLE 1'h1

`endif

// ---- rtl/adcsr_pkg.sv ----
/*
 * Types shared by the serial readout: core states, the state records
 * of both clock domains, and the carriers for codes and the data pin.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package adcsr_pkg;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic [9:0] data;
      logic [1:0] sub;
   } adcsr_code_t;

   typedef struct packed {
      logic data;
      logic oe;
   } adcsr_dout_t;

   // ****************************************************************
   // State records
   // ****************************************************************
   typedef enum logic [1:0] {
      ADCSR_IDLE,
      ADCSR_CONV,
      ADCSR_HOLD
   } adcsr_core_st_t;

   typedef struct packed {
      logic [4:0] cnt;
      logic mode_int;
      logic req;
      logic [11:0] data;
      logic out_bit;
   } adcsr_link_t;

   typedef struct packed {
      adcsr_core_st_t state;
      logic cs_prev;
      logic power;
      logic chan_next;
      logic chan_cur;
      logic mode_int;
      logic [15:0] timer;
      adcsr_code_t result;
      logic ack;
      logic eoc;
      logic sample;
   } adcsr_core_t;

endpackage

// ---- rtl/adcsr_sync.sv ----
/*
 * Two-flop level synchroniser of parameter width.
 * Assumes each bit is a level that is stable for several clocks.
 */
`timescale 1ns/100ps
`default_nettype none

module adcsr_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } adcsr_sync_st_t;

   adcsr_sync_st_t st_q;
   adcsr_sync_st_t st_d;

   // First stage feeds only the second
   always_comb begin
      st_d = st_q;
      if (ce_i) begin
         st_d.s1 = d_i;
         st_d.s2 = st_q.s1;
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q_o = st_q.s2;

endmodule // adcsr_sync

`default_nettype wire

// ---- bench/adcsr_host.sv ----
/*
 * Behavioural host master at the far side of the readout link: drives
 * the select pin and a 160 ns shift clock, captures the data pin.
 * Assumes a start pulse from the bench; the clock is still between
 * frames and each frame ends with busy_o low.
 */
`timescale 1ns/100ps
`default_nettype none

module adcsr_host
   import adcsr_pkg::*;
(
   input wire logic start_i,
   input wire logic mode_int_i,
   input wire logic [5:0] nclk_i,
   input wire adcsr_dout_t dout_i,
   output logic sclk_o,
   output logic sel_n_o,
   output logic [31:0] word_o,
   output logic busy_o
);
   // ****************************************************************
   // Frame sequencer
   // ****************************************************************
   initial begin
      sclk_o = 1'b0;
      sel_n_o = 1'b1;
      word_o = '0;
      busy_o = 1'b0;
   end

   // One whole frame per start pulse
   always @(posedge start_i) begin : frame
      int k;
      int w;
      busy_o = 1'b1;
      word_o = '0;
      sclk_o = mode_int_i;
      #20 sel_n_o = 1'b0;
      #2500 sclk_o = 1'b1;
      for (k = 0; k < nclk_i; k++) begin
         #80 sclk_o = 1'b0;
         #80;
         // Done flag comes on its own time, not on the clock
         for (w = 0; w < 400 && mode_int_i && k == 0 &&
              dout_i.data !== 1'b1; w++)
            #50;
         sclk_o = 1'b1;
         word_o = {word_o[30:0], dout_i.oe ? dout_i.data : 1'bx};
      end
      // end frame, then hold select high
      #80 sel_n_o = 1'b1;
      // Clock drops only once the link is held in reset
      #20 sclk_o = 1'b0;
      #80 busy_o = 1'b0;
   end
endmodule // adcsr_host

`default_nettype wire

// ---- bench/testbench.sv ----
/*
 * Self-checking bench of the converter serial readout: external and
 * internal frames, trailing zeros, an aborted frame, channel order.
 * Assumes the host model and a 20 MHz system clock.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import adcsr_pkg::*;
   logic clk_i, rst_i, start, mode, busy, exp_ch, ce, frz;
   logic [5:0] nclk;
   logic [31:0] word;
   logic sclk, sel_n, core_power_o, core_sample_o, core_chan_o;
   adcsr_code_t code0, code1;
   adcsr_dout_t serial_out_o;
   int n_errors = 0;
   int total_checks = 0;
   int n_smp = 0;

   // ****************************************************************
   // Design, host and clocks
   // ****************************************************************
   adcsr_top #(.INT_CONV_CYCLES(16'h0004), .DUAL_CHANNEL(1'b1)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .sclk_i(sclk),
      .select_shutdown_n_i(sel_n), .ch0_code_i(code0), .ch1_code_i(code1),
      .serial_out_o(serial_out_o), .core_power_o(core_power_o),
      .core_sample_o(core_sample_o), .core_chan_o(core_chan_o));

   adcsr_host u_host (.start_i(start), .mode_int_i(mode), .nclk_i(nclk),
      .dout_i(serial_out_o), .sclk_o(sclk), .sel_n_o(sel_n),
      .word_o(word), .busy_o(busy));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // Sample pulses, counted per frame
   always @(posedge clk_i)
      if (core_sample_o === 1'b1)
         n_smp <= n_smp + 1;

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One frame, judged on word, sample count, power, channel and pin
   task automatic run(input string nm, input logic md, input logic [5:0] n);
      logic [31:0] e;
      int s0;
      int t;
      e = {16'h0, 3'h7, exp_ch, exp_ch ? code1 : code0};
      e = (n < 16) ? e >> (16 - n) : e << (n - 16);
      s0 = n_smp;
      @(posedge clk_i);
      mode <= md;
      nclk <= n;
      start <= 1'b1;
      ce <= ~frz;
      @(posedge clk_i);
      start <= 1'b0;
      // Inside the wake-up wait, before any shift clock; a frozen
      // core must not see the select fall until enable returns
      repeat (20) @(posedge clk_i);
      if (frz) begin
         check("frozen power", 32'h0, core_power_o);
         ce <= 1'b1;
      end
      repeat (20) @(posedge clk_i);
      check("power", 32'h1, core_power_o);
      check("chan", exp_ch, core_chan_o);
      check("oe", 32'h1, serial_out_o.oe);
      for (t = 0; t < 4000 && busy !== 1'b0; t++)
         @(posedge clk_i);
      // A frame that never ends counts as a mismatch
      if (busy !== 1'b0)
         n_errors++;
      repeat (6) @(posedge clk_i);
      check("word", e, word);
      check("samples", (md || n > 1) ? 1 : 0, n_smp - s0);
      check("power off", 32'h0, core_power_o);
      check("oe off", 32'h0, serial_out_o.oe);
      // Channel moves on every select fall, used or not
      exp_ch = ~exp_ch;
      $display("test %s done", nm);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_external;
      run("external", 1'b0, 6'd16);
   endtask

   task automatic t_trailing;
      run("trailing", 1'b0, 6'd20);
   endtask

   task automatic t_internal;
      run("internal", 1'b1, 6'd16);
   endtask

   task automatic t_abort;
      run("abort", 1'b0, 6'd1);
      run("restart", 1'b0, 6'd16);
   endtask

   // Clock enable low through the select fall delays the core only
   task automatic t_freeze;
      frz = 1'b1;
      run("freeze", 1'b0, 6'd16);
      frz = 1'b0;
   endtask

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      rst_i = 1'b1;
      start = 1'b0;
      mode = 1'b0;
      nclk = 6'h00;
      exp_ch = 1'b0;
      ce = 1'b1;
      frz = 1'b0;
      code0 = 12'hab6;
      code1 = 12'h549;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      t_external();
      code0 <= 12'h35a;
      t_trailing();
      t_internal();
      t_abort();
      t_freeze();
      report_and_stop();
   end

   // Six frames need about 33 us
   initial begin
      #200000;
      n_errors++;
      report_and_stop();
   end
endmodule // testbench

`default_nettype wire
